// *** usiss_pkg.sv ***
// Constants, field layouts and types shared by the serial shift and status block
package usiss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          APB_AW   = 12;
  localparam int          APB_DW   = 32;
  localparam int          REG_W    = 8;
  localparam int          CNT_W    = 4;
  localparam int          SYNC_LEN = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses, one aligned word each
  localparam logic [APB_AW-1:0] OFS_SHIFT_DATA = 12'h000;
  localparam logic [APB_AW-1:0] OFS_RX_BUFFER  = 12'h004;
  localparam logic [APB_AW-1:0] OFS_STATUS     = 12'h008;
  localparam logic [APB_AW-1:0] OFS_CONTROL    = 12'h00C;

  ////////////////////////////////////////////////////////////////////////////
  // Status register bit positions
  localparam int          ST_START = 7;
  localparam int          ST_OVF   = 6;
  localparam int          ST_STOP  = 5;
  localparam int          ST_COLL  = 4;

  // Control register strobe bit positions (write only, read as zero)
  localparam int          CT_SWCLK = 1;
  localparam int          CT_TOGL  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [REG_W-1:0] SHIFT_RST = 8'h00;
  localparam logic [REG_W-1:0] RXBUF_RST = 8'h00;
  localparam logic [REG_W-1:0] CTRL_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_MAX   = 4'hF;
  localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
  localparam logic [1:0]       STROBE_RD = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Wire modes and clock sources
  localparam logic [1:0]  WM_OFF      = 2'h0;
  localparam logic [1:0]  WM_THREE    = 2'h1;
  localparam logic [1:0]  WM_TWO      = 2'h2;
  localparam logic [1:0]  WM_TWO_HOLD = 2'h3;
  localparam logic [1:0]  CS_SOFT     = 2'h0;
  localparam logic [1:0]  CS_TIMER    = 2'h1;
  localparam logic [1:0]  CS_EXT_POS  = 2'h2;
  localparam logic [1:0]  CS_EXT_NEG  = 2'h3;

  // Control register layout, msb first as seen by software
  typedef struct packed {
    logic       start_interrupt_enable;
    logic       overflow_interrupt_enable;
    logic [1:0] wire_mode_field;
    logic [1:0] clock_source_select;
    logic       software_clock_bit;
    logic       toggle_clock_strobe;
  } usiss_ctrl_t;

  // Sticky line and interrupt flags
  typedef struct packed {
    logic start_condition_flag;
    logic counter_overflow_flag;
    logic stop_condition_flag;
  } usiss_flags_t;

endpackage : usiss_pkg

// *** usiss_core.sv ***
// Serial shift register, receive buffer, clock counter and status flags behind an APB slave

module usiss_core (
  // Clock and reset
  input  logic                          pclk,
  input  logic                          presetn,
  // APB slave
  input  logic                          psel,
  input  logic                          penable,
  input  logic                          pwrite,
  input  logic [usiss_pkg::APB_AW-1:0]  paddr,
  input  logic [usiss_pkg::APB_DW-1:0]  pwdata,
  output logic                          pready,
  output logic [usiss_pkg::APB_DW-1:0]  prdata,
  output logic                          pslverr,
  // Serial pins, sensed levels from outside the clock domain
  input  logic                          serial_input_pin,
  input  logic                          shift_clock_pin,
  // Port logic of the same clock domain
  input  logic                          ddr_do,
  input  logic                          ddr_sda,
  input  logic                          ddr_scl,
  input  logic                          port_sda,
  input  logic                          port_scl,
  input  logic                          timer0_match,
  input  logic                          global_int_enable,
  input  logic                          sleep_active,
  input  logic                          sleep_idle,
  // Pin drivers, enables active low
  output logic                          do_out,
  output logic                          do_oe_n,
  output logic                          sda_out,
  output logic                          sda_oe_n,
  output logic                          scl_out,
  output logic                          scl_oe_n,
  output logic                          sck_toggle,
  // Interrupt and wake requests
  output logic                          start_irq,
  output logic                          ovf_irq,
  output logic                          wake_req
);
  import usiss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [SYNC_LEN-1:0] di_sync;
  logic [SYNC_LEN-1:0] sck_sync;
  logic                di_lvl;
  logic                sck_lvl;
  logic [REG_W-1:0]    serial_shift_data;
  logic [REG_W-1:0]    receive_buffer;
  logic [CNT_W-1:0]    clock_counter_value;
  usiss_ctrl_t         serial_control;
  usiss_flags_t        flags;
  logic                start_hold;

  // Combinational terms
  logic                di_chg;
  logic                sck_chg;
  logic                sda_rise;
  logic                sda_fall;
  logic                sck_rise;
  logic                sck_fall;
  logic                wr_cyc;
  logic                sel_data;
  logic                sel_buf;
  logic                sel_stat;
  logic                sel_ctrl;
  logic                unmapped;
  logic                wr_data;
  logic                wr_stat;
  logic                wr_ctrl;
  logic                clk_strobe;
  logic                tc_strobe;
  logic                eff_sw_clk;
  logic                two_wire;
  logic                shift_evt;
  logic                cnt_evt;
  logic                ovf_evt;
  logic                start_det;
  logic                stop_det;
  logic                start_set;
  logic                latch_open;
  logic                output_collision_bit;
  logic [REG_W-1:0]    next_serial_shift_data;
  logic                next_out_latch;
  usiss_flags_t        next_flags;
  logic                next_start_hold;
  logic                next_ovf_hold;
  logic [REG_W-1:0]    rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      di_sync  <= '0;
      sck_sync <= '0;
    end else begin
      di_sync  <= {di_sync[SYNC_LEN-2:0], serial_input_pin};
      sck_sync <= {sck_sync[SYNC_LEN-2:0], shift_clock_pin};
    end
  end

  // Filtered levels; stage one is read only by stage two
  assign di_chg  = (di_sync[1] == di_sync[2]) && (di_sync[2] != di_lvl);
  assign sck_chg = (sck_sync[1] == sck_sync[2]) && (sck_sync[2] != sck_lvl);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      di_lvl  <= 1'b0;
      sck_lvl <= 1'b0;
    end else begin
      if (di_chg) begin
        di_lvl <= di_sync[2];
      end
      if (sck_chg) begin
        sck_lvl <= sck_sync[2];
      end
    end
  end

  // Edge events, one cycle each
  assign sda_rise = di_chg && di_sync[2];
  assign sda_fall = di_chg && !di_sync[2];
  assign sck_rise = sck_chg && sck_sync[2];
  assign sck_fall = sck_chg && !sck_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // APB address decode; one wait state, so a write lands when pready is high
  always_comb begin
    sel_data = 1'b0;
    sel_buf  = 1'b0;
    sel_stat = 1'b0;
    sel_ctrl = 1'b0;
    unmapped = 1'b0;
    if (paddr == OFS_SHIFT_DATA) begin
      sel_data = 1'b1;
    end else if (paddr == OFS_RX_BUFFER) begin
      sel_buf = 1'b1;
    end else if (paddr == OFS_STATUS) begin
      sel_stat = 1'b1;
    end else if (paddr == OFS_CONTROL) begin
      sel_ctrl = 1'b1;
    end else begin
      unmapped = 1'b1;
    end
  end

  assign wr_cyc  = psel && penable && pready && pwrite;
  assign wr_data = wr_cyc && sel_data;
  assign wr_stat = wr_cyc && sel_stat;
  assign wr_ctrl = wr_cyc && sel_ctrl;

  // Software strobes come from writes of one to the control strobe bits
  assign clk_strobe = wr_ctrl && pwdata[CT_SWCLK];
  assign tc_strobe  = wr_ctrl && pwdata[CT_TOGL];
  assign eff_sw_clk = wr_ctrl ? pwdata[CT_SWCLK] : serial_control.software_clock_bit;
  assign two_wire   = serial_control.wire_mode_field[1];

  ////////////////////////////////////////////////////////////////////////////
  // Clock source selection; inputs work in every wire mode
  always_comb begin
    shift_evt = 1'b0;
    cnt_evt   = 1'b0;
    case (serial_control.clock_source_select)
      CS_SOFT: begin
        shift_evt = clk_strobe;
        cnt_evt   = clk_strobe;
      end
      CS_TIMER: begin
        shift_evt = timer0_match;
        cnt_evt   = timer0_match;
      end
      CS_EXT_POS: begin
        shift_evt = sck_rise;
        cnt_evt   = eff_sw_clk ? tc_strobe : sck_chg;
      end
      default: begin
        shift_evt = sck_fall;
        cnt_evt   = eff_sw_clk ? tc_strobe : sck_chg;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register: a CPU write beats a coincident shift
  always_comb begin
    if (wr_data) begin
      next_serial_shift_data = pwdata[REG_W-1:0];
    end else if (shift_evt) begin
      next_serial_shift_data = {serial_shift_data[REG_W-2:0], di_lvl};
    end else begin
      next_serial_shift_data = serial_shift_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_shift_data <= SHIFT_RST;
    end else begin
      serial_shift_data <= next_serial_shift_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock counter; a CPU write of the count beats a coincident increment
  assign ovf_evt = cnt_evt && !wr_stat && (clock_counter_value == CNT_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_counter_value <= CNT_RST;
    end else if (wr_stat) begin
      clock_counter_value <= pwdata[CNT_W-1:0];
    end else if (cnt_evt) begin
      clock_counter_value <= clock_counter_value + CNT_ONE;
    end
  end

  // Completed byte lands in the buffer so software may read it at leisure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer <= RXBUF_RST;
    end else if (ovf_evt) begin
      receive_buffer <= next_serial_shift_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; both strobe bits are stored like the rest, though reads return them as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control <= usiss_ctrl_t'(CTRL_RST);
    end else if (wr_ctrl) begin
      serial_control <= usiss_ctrl_t'(pwdata[REG_W-1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions are seen only on the filtered levels, so glitches cannot fake one
  assign start_det = sda_fall && sck_lvl;
  assign stop_det  = sda_rise && sck_lvl;
  assign start_set = (two_wire && start_det)
                   || (!two_wire && serial_control.clock_source_select[1]
                       && !serial_control.software_clock_bit && sck_chg);

  // Set beats clear; a written zero leaves a flag alone
  always_comb begin
    next_flags.start_condition_flag  = start_set
        || (flags.start_condition_flag && !(wr_stat && pwdata[ST_START]));
    next_flags.counter_overflow_flag = ovf_evt
        || (flags.counter_overflow_flag && !(wr_stat && pwdata[ST_OVF]));
    next_flags.stop_condition_flag   = (two_wire && stop_det)
        || (flags.stop_condition_flag && !(wr_stat && pwdata[ST_STOP]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // Start hold grabs the clock line after the master's first falling edge
  assign next_start_hold = two_wire && next_flags.start_condition_flag
                         && (start_hold || sck_fall);
  assign next_ovf_hold   = (serial_control.wire_mode_field == WM_TWO_HOLD)
                         && next_flags.counter_overflow_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_hold <= 1'b0;
    end else begin
      start_hold <= next_start_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latch: closed in the half cycle where the far end samples
  assign latch_open     = !serial_control.clock_source_select[1]
                        || (sck_lvl == serial_control.clock_source_select[0]);
  assign next_out_latch = latch_open ? next_serial_shift_data[REG_W-1] : do_out;

  // Pin drivers; open-drain lines only ever pull low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_out   <= 1'b0;
      do_oe_n  <= 1'b1;
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_out  <= 1'b0;
      scl_oe_n <= 1'b1;
    end else begin
      do_out   <= next_out_latch;
      do_oe_n  <= !((serial_control.wire_mode_field == WM_THREE) && ddr_do);
      sda_out  <= 1'b0;
      sda_oe_n <= !(two_wire && ddr_sda && (!next_out_latch || !port_sda));
      scl_out  <= 1'b0;
      scl_oe_n <= !(two_wire && ddr_scl
                    && (!port_scl || next_start_hold || next_ovf_hold));
    end
  end

  // Toggle strobe also asks the port logic to flip the clock pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_toggle <= 1'b0;
    end else begin
      sck_toggle <= tc_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and wake requests; the overflow flag never wakes deeper sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_irq <= 1'b0;
      ovf_irq   <= 1'b0;
      wake_req  <= 1'b0;
    end else begin
      start_irq <= flags.start_condition_flag
                && serial_control.start_interrupt_enable && global_int_enable;
      ovf_irq   <= flags.counter_overflow_flag
                && serial_control.overflow_interrupt_enable && global_int_enable;
      wake_req  <= sleep_active
                && ((flags.start_condition_flag && serial_control.start_interrupt_enable)
                    || (flags.counter_overflow_flag && sleep_idle
                        && serial_control.overflow_interrupt_enable));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read side; no read has a side effect, buffer and data alike
  assign output_collision_bit = serial_shift_data[REG_W-1] != di_lvl;

  always_comb begin
    rd_byte = '0;
    if (sel_data) begin
      rd_byte = serial_shift_data;
    end else if (sel_buf) begin
      rd_byte = receive_buffer;
    end else if (sel_stat) begin
      rd_byte = {flags, output_collision_bit, clock_counter_value};
    end else if (sel_ctrl) begin
      rd_byte = {serial_control[REG_W-1:2], STROBE_RD};
    end
  end

  // Answer one cycle into the access phase; unmapped addresses get an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && unmapped;
      if (psel && penable && !pready) begin
        prdata <= APB_DW'(rd_byte);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_start_seen;
    two_wire && start_det;
  endsequence

  sequence s_start_no_clear;
    flags.start_condition_flag && !(wr_stat && pwdata[ST_START]);
  endsequence

  sequence s_wrap;
    cnt_evt && !wr_stat && (clock_counter_value == CNT_MAX);
  endsequence

  AST_WRITE_WINS: assert property (wr_data |=> serial_shift_data == $past(pwdata[REG_W-1:0]))
    else $error("data write lost to a shift");
  AST_SHIFT_LEFT: assert property (shift_evt && !wr_data
      |=> serial_shift_data == {$past(serial_shift_data[REG_W-2:0]), $past(di_lvl)})
    else $error("shift did not move left");
  AST_OFF_MODE_SHIFT: assert property ((serial_control.wire_mode_field == WM_OFF)
      && sck_rise && (serial_control.clock_source_select == CS_EXT_POS) && !wr_data
      |=> serial_shift_data[REG_W-1:1] == $past(serial_shift_data[REG_W-2:0]))
    else $error("no shift with outputs off");
  AST_LATCH_OPEN: assert property (!serial_control.clock_source_select[1]
      |=> do_out == serial_shift_data[REG_W-1])
    else $error("latch not transparent for internal clock");
  AST_LATCH_HOLD: assert property (serial_control.clock_source_select[1]
      && (sck_lvl != serial_control.clock_source_select[0]) |=> $stable(do_out))
    else $error("output changed in sampling half");
  AST_DO_DIR: assert property (!ddr_do |=> do_oe_n)
    else $error("data output driven while input");
  AST_BUF_COPY: assert property (ovf_evt |=> receive_buffer == serial_shift_data)
    else $error("buffer missed completed byte");
  AST_START_SET: assert property (s_start_seen |=> flags.start_condition_flag ##1 start_irq
      || !(serial_control.start_interrupt_enable && global_int_enable))
    else $error("start condition not flagged");
  AST_START_STICKY: assert property (s_start_no_clear |=> flags.start_condition_flag)
    else $error("start flag cleared without written one");
  AST_OVF_WRAP: assert property (s_wrap
      |=> flags.counter_overflow_flag && (clock_counter_value == CNT_RST))
    else $error("overflow not flagged at wrap");
  AST_OVF_HOLD: assert property ((serial_control.wire_mode_field == WM_TWO_HOLD) && ddr_scl
      && !wr_ctrl && flags.counter_overflow_flag && !(wr_stat && pwdata[ST_OVF]) |=> !scl_oe_n)
    else $error("clock not held after overflow");
  AST_CNT_INC: assert property (cnt_evt && !wr_stat
      |=> clock_counter_value == $past(clock_counter_value) + CNT_ONE)
    else $error("counter did not step");

endmodule : usiss_core

// *** usiss_peer.sv ***
// Behavioural serial master that clocks bytes into the block
module usiss_peer (
  // Serial lines
  output logic sck,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands still low between frames
  initial begin
    sck = 1'h0;
    sdi = 1'h0;
  end
  // MSB first, data set a quarter period before the rise, 160 ns period
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      #40 sck = 1'h1;
      #80 sck = 1'h0;
      #40;
    end
    sdi = ~sdi; // Released line must not keep showing the last bit
  endtask : send
endmodule : usiss_peer

// *** usiss_tb.sv ***
// Self-checking bench for the serial shift and status block
module tb;
  import usiss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic e;} usiss_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sck, sdi;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [8:0] misc = 9'h1C6; // ddr_do, gie and sleep high, Idle low
  logic do_out, do_oe_n, start_irq, ovf_irq, wake_req, e;
  logic [7:0] q;
  int errors = 0, num_checks = 0;
  // Reads expect d; writes only the error response
  usiss_row_t rows[16] = '{{1'h0,12'h000,8'h00,1'h0}, {1'h0,12'h004,8'h00,1'h0}, {1'h0,12'h008,8'h00,1'h0},
    {1'h0,12'h00C,8'h00,1'h0}, {1'h1,12'h000,8'h3C,1'h0}, {1'h0,12'h000,8'h3C,1'h0}, {1'h1,12'h004,8'hFF,1'h0},
    {1'h0,12'h004,8'h00,1'h0}, {1'h1,12'h008,8'h0E,1'h0}, {1'h0,12'h008,8'h0E,1'h0}, {1'h1,12'h00C,8'h02,1'h0},
    {1'h0,12'h000,8'h78,1'h0}, {1'h1,12'h00C,8'h02,1'h0}, {1'h0,12'h008,8'h40,1'h0}, {1'h0,12'h004,8'hF0,1'h0},
    {1'h0,12'h010,8'h00,1'h1}};
  usiss_peer peer (.sck(sck), .sdi(sdi));
  usiss_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .serial_input_pin(sdi),
    .shift_clock_pin(sck), .ddr_do(misc[8]), .ddr_sda(misc[7]), .ddr_scl(misc[6]), .port_sda(misc[5]),
    .port_scl(misc[4]), .timer0_match(misc[3]), .global_int_enable(misc[2]), .sleep_active(misc[1]),
    .sleep_idle(misc[0]), .do_out(do_out), .do_oe_n(do_oe_n), .sda_out(), .sda_oe_n(), .scl_out(),
    .scl_oe_n(), .sck_toggle(), .start_irq(start_irq), .ovf_irq(ovf_irq), .wake_req(wake_req));
  ////////////////////////////////////////
  // Clock, reset release on an edge, hang guard
  initial forever #2.5 pclk = ~pclk;
  initial begin
    #200000;
    errors++;
    conclude();
  end
  // One APB transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata[7:0];
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  // Table first, then a received frame and the sticky flags; collision bit masked in the table only
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q & 8'hEF, rows[i].d & 8'hEF);
      chk({7'h0, e}, {7'h0, rows[i].e});
    end
    $display("register table done");
    apb(1'h1, 12'h008, 8'h40);
    apb(1'h1, 12'h00C, 8'hD8);
    peer.send(8'hA5);
    repeat (10) @(posedge pclk);
    chk({3'h0, do_oe_n, do_out, start_irq, ovf_irq, wake_req}, 8'h0F);
    apb(1'h0, 12'h004, 8'h00);
    chk(q, 8'hA5);
    apb(1'h1, 12'h008, 8'h00);
    apb(1'h0, 12'h008, 8'h00);
    chk(q, 8'hD0);
    $display("frame done");
    apb(1'h1, 12'h008, 8'hE0);
    apb(1'h0, 12'h008, 8'h00);
    chk(q, 8'h10);
    chk({6'h0, start_irq, ovf_irq}, 8'h00);
    $display("flag clear done");
    // Mid-run reset brings the status and count back to zero
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 12'h008, 8'h00);
    chk(q, 8'h00);
    $display("mid-run reset done");
    conclude();
  end
endmodule : tb
